// file: pdadj_pkg.sv
// Functional notes
// - Adjustment runs only while the enable bit (control bit 7) is 1.
// - Direction bit 0: over-voltage raises, under-voltage lowers duty; 1 reverses.
// - Source bit 0: staging loads firmware compare; 1: adjust engine loads it.
// - Source bit is held 0 while enable is 0.
// - While enabled, any over- or under-voltage level sets the source bit.
// - Clearing the source bit works only while both voltage levels are 0.
// - Status bit 3 shows the debounced over-voltage level.
// - Status bit 2 shows the debounced under-voltage level.
// - Status bit 1 shows the filtered second over-current level.
// - Status bit 0 shows the filtered first over-current level.
// - Ten-bit read/write maximum duty in high (bits 1..0) and low registers.
// - Ten-bit read/write minimum duty in high (bits 1..0) and low registers.
// - Staging duty readable, not writable, high and low parts, reset 0.
// - Unimplemented bits of control and high registers read 0.
// - Enable, direction and source bits reset to 0; status bits are live.
// - Steps are spaced (delay field + 1) times two timer periods.
// - Step size 0..15 from upper (over) or lower (under) nibble.
// - Staging duty is forced to zero while adjustment is disabled.
// - With timer running, compare takes staging value (firmware compare while disabled) only at counter zero.
package pdadj_pkg;

    localparam int APB_ADDR_W = 8;
    localparam int DUTY_W     = 10;
    localparam int DELAY_W    = 6;
    localparam int STEP_W     = 4;
    localparam int WAIT_W     = 8;

    // Register byte addresses
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_DELAY  = 8'h04;
    localparam logic [7:0] OFS_STEP   = 8'h08;
    localparam logic [7:0] OFS_MAXH   = 8'h0c;
    localparam logic [7:0] OFS_MAXL   = 8'h10;
    localparam logic [7:0] OFS_MINH   = 8'h14;
    localparam logic [7:0] OFS_MINL   = 8'h18;
    localparam logic [7:0] OFS_STAGEH = 8'h1c;
    localparam logic [7:0] OFS_STAGEL = 8'h20;

    // Control and status field positions
    localparam int BIT_EN  = 7;
    localparam int BIT_DIR = 6;
    localparam int BIT_SRC = 5;
    localparam int BIT_OV  = 3;
    localparam int BIT_UV  = 2;
    localparam int BIT_OCB = 1;
    localparam int BIT_OCA = 0;
    localparam int OV_STEP_LSB = 4;
    localparam int UV_STEP_LSB = 0;

    // Reset values
    localparam logic              RST_BIT   = 1'b0;
    localparam logic [DUTY_W-1:0] RST_DUTY  = 10'h000;
    localparam logic [DELAY_W-1:0] RST_DELAY = 6'h00;
    localparam logic [7:0]        RST_STEP  = 8'h00;

    // Timer periods per delay unit
    localparam logic [WAIT_W-1:0] PERIODS_PER_UNIT = 8'h02;

    // Live comparator levels, as seen after their own debounce or filter
    typedef struct packed {
        logic ov;
        logic uv;
        logic ocB;
        logic ocA;
    } pdadj_comp_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_HOLD = 1'b1
    } pdadj_state_t;

endpackage

// file: pdadj_sync.sv
`timescale 1ns/1ps
// Two-stage level synchroniser; only the second stage is visible
module pdadj_sync
    import pdadj_pkg::*;
#(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         reset_n,
    // Levels
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    // First stage feeds the second stage only
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule

// file: pdadj_step.sv
`timescale 1ns/1ps
// Saturating duty step; result is clamped into [minDuty, maxDuty] when minDuty <= maxDuty
module pdadj_step
    import pdadj_pkg::*;
(
    // Operands
    input  wire logic [DUTY_W-1:0] duty,
    input  wire logic [STEP_W-1:0] step,
    input  wire logic              up,
    input  wire logic [DUTY_W-1:0] minDuty,
    input  wire logic [DUTY_W-1:0] maxDuty,
    // Result
    output logic      [DUTY_W-1:0] nextDuty
);
    logic [DUTY_W:0] sumWide;
    logic [DUTY_W:0] diffWide;
    logic [DUTY_W:0] raw;

    // One extra bit catches overflow and underflow instead of wrapping
    assign sumWide  = {1'b0, duty} + {{(DUTY_W + 1 - STEP_W){1'b0}}, step};
    assign diffWide = {1'b0, duty} - {{(DUTY_W + 1 - STEP_W){1'b0}}, step};
    assign raw      = up ? sumWide : diffWide;

    // Saturate at the limits; with crossed limits a result above maximum gives maximum, any other gives minimum
    always_comb begin
        if (!up && diffWide[DUTY_W]) begin
            nextDuty = minDuty;
        end else if (raw > {1'b0, maxDuty}) begin
            nextDuty = maxDuty;
        end else if (raw < {1'b0, minDuty}) begin
            nextDuty = minDuty;
        end else begin
            nextDuty = raw[DUTY_W-1:0];
        end
    end
endmodule

// file: pdadj_ctrl.sv
`timescale 1ns/1ps
module pdadj_ctrl
    import pdadj_pkg::*;
(
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Comparator levels from the protection block
    input  wire pdadj_comp_t           compIn,
    // PWM timer side
    input  wire logic                  timerRunning,
    input  wire logic                  timerZero,
    input  wire logic                  timerPeriodEnd,
    input  wire logic                  fwCompareWrite,
    input  wire logic [DUTY_W-1:0]     fwCompareData,
    output logic      [DUTY_W-1:0]     timerCompareValue,
    output logic                       bufferSourceSelect
);
    // Registers
    logic              enable_q, enable_d;
    logic              dir_q;
    logic              src_d;
    logic [DELAY_W-1:0] delay_q;
    logic [7:0]        step_q;
    logic [DUTY_W-1:0] max_q, min_q, staging_q, staging_d, fwCcra_q;
    logic [DUTY_W-1:0] compare_d;
    logic [WAIT_W-1:0] wait_q, wait_d;
    pdadj_state_t      state_q, state_d;
    pdadj_comp_t       comp;

    // Comparator levels cross into the system clock here
    pdadj_sync #(.W(4)) u_sync (
        .clock   (clock),
        .reset_n (reset_n),
        .asyncIn (compIn),
        .syncOut (comp)
    );

    // APB decode
    wire setupPh = psel && !penable;
    wire accessW = psel && penable && pready && pwrite && !pslverr;
    wire hitCtrl  = (paddr == OFS_CTRL);
    wire hitDelay = (paddr == OFS_DELAY);
    wire hitStep  = (paddr == OFS_STEP);
    wire hitMaxH  = (paddr == OFS_MAXH);
    wire hitMaxL  = (paddr == OFS_MAXL);
    wire hitMinH  = (paddr == OFS_MINH);
    wire hitMinL  = (paddr == OFS_MINL);
    wire hitStgH  = (paddr == OFS_STAGEH);
    wire hitStgL  = (paddr == OFS_STAGEL);
    wire mapped   = hitCtrl || hitDelay || hitStep || hitMaxH || hitMaxL
                    || hitMinH || hitMinL || hitStgH || hitStgL;
    // Staging registers are read only, so a write to them is refused
    wire badAcc   = !mapped || (pwrite && (hitStgH || hitStgL));
    wire ctrlWr   = accessW && hitCtrl;

    // Read mux; unimplemented bits read zero
    logic [7:0] ctrlView;
    logic [7:0] rdByte;
    assign ctrlView = {enable_q, dir_q, bufferSourceSelect, 1'b0,
                       comp.ov, comp.uv, comp.ocB, comp.ocA};
    assign rdByte =
        hitCtrl  ? ctrlView :
        hitDelay ? {2'b00, delay_q} :
        hitStep  ? step_q :
        hitMaxH  ? {6'h00, max_q[9:8]} :
        hitMaxL  ? max_q[7:0] :
        hitMinH  ? {6'h00, min_q[9:8]} :
        hitMinL  ? min_q[7:0] :
        hitStgH  ? {6'h00, staging_q[9:8]} :
        hitStgL  ? staging_q[7:0] : 8'h00;

    // Answer one cycle after setup: zero wait states
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setupPh;
            pslverr <= setupPh && badAcc;
            prdata  <= (setupPh && !pwrite) ? {24'h00_0000, rdByte} : 32'h0000_0000;
        end
    end

    // Software-written configuration
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            dir_q   <= RST_BIT;
            delay_q <= RST_DELAY;
            step_q  <= RST_STEP;
            max_q   <= RST_DUTY;
            min_q   <= RST_DUTY;
        end else if (accessW) begin
            if (hitCtrl)  dir_q         <= pwdata[BIT_DIR];
            if (hitDelay) delay_q       <= pwdata[DELAY_W-1:0];
            if (hitStep)  step_q        <= pwdata[7:0];
            if (hitMaxH)  max_q[9:8]    <= pwdata[1:0];
            if (hitMaxL)  max_q[7:0]    <= pwdata[7:0];
            if (hitMinH)  min_q[9:8]    <= pwdata[1:0];
            if (hitMinL)  min_q[7:0]    <= pwdata[7:0];
        end
    end

    // Enable takes the written value; source logic sees the new value at once
    assign enable_d = ctrlWr ? pwdata[BIT_EN] : enable_q;

    // Source select: forced low when disabled, set by any voltage level,
    // and a software clear only lands while both levels are quiet
    wire lvlAny = comp.ov || comp.uv;
    always_comb begin
        if (!enable_d) begin
            src_d = 1'b0;
        end else if (lvlAny) begin
            src_d = 1'b1;
        end else if (ctrlWr) begin
            src_d = pwdata[BIT_SRC];
        end else begin
            src_d = bufferSourceSelect;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            enable_q           <= RST_BIT;
            bufferSourceSelect <= RST_BIT;
        end else begin
            enable_q           <= enable_d;
            bufferSourceSelect <= src_d;
        end
    end

    // Step request: over-voltage takes priority when both levels stand
    wire              stepFire = enable_q && enable_d && lvlAny && (state_q == ST_IDLE);
    wire              stepUp   = comp.ov ? !dir_q : dir_q;
    wire [STEP_W-1:0] stepSize = comp.ov ? step_q[OV_STEP_LSB +: STEP_W]
                                         : step_q[UV_STEP_LSB +: STEP_W];
    wire [DUTY_W-1:0] stepped;

    pdadj_step u_step (
        .duty     (staging_q),
        .step     (stepSize),
        .up       (stepUp),
        .minDuty  (min_q),
        .maxDuty  (max_q),
        .nextDuty (stepped)
    );

    // Spacing between steps in timer periods: (delay + 1) * 2
    wire [WAIT_W-1:0] waitLoad = WAIT_W'(({2'b00, delay_q} + 8'h01) * PERIODS_PER_UNIT);

    // Step spacing state machine; disabling abandons any pending wait
    always_comb begin
        state_d = state_q;
        wait_d  = wait_q;
        case (state_q)
            ST_IDLE: begin
                if (stepFire) begin
                    state_d = ST_HOLD;
                    wait_d  = waitLoad;
                end
            end
            ST_HOLD: begin
                if (!enable_q) begin
                    state_d = ST_IDLE;
                end else if (timerPeriodEnd) begin
                    wait_d = wait_q - 8'h01;
                    if (wait_q == 8'h01) begin
                        state_d = ST_IDLE;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Staging duty: zero when disabled, else engine or firmware source
    always_comb begin
        if (!enable_d) begin
            staging_d = RST_DUTY;
        end else if (stepFire) begin
            staging_d = stepped;
        end else if (!bufferSourceSelect && fwCompareWrite) begin
            staging_d = fwCompareData;
        end else begin
            staging_d = staging_q;
        end
    end

    // Compare value follows staging (firmware compare while disabled) only at counter zero while timer runs
    wire [DUTY_W-1:0] cmpSrc = enable_q ? staging_q : fwCcra_q;
    assign compare_d = (!timerRunning || timerZero) ? cmpSrc : timerCompareValue;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q           <= ST_IDLE;
            wait_q            <= 8'h00;
            staging_q         <= RST_DUTY;
            fwCcra_q          <= RST_DUTY;
            timerCompareValue <= RST_DUTY;
        end else begin
            state_q           <= state_d;
            wait_q            <= wait_d;
            staging_q         <= staging_d;
            if (fwCompareWrite) fwCcra_q <= fwCompareData;
            timerCompareValue <= compare_d;
        end
    end

    // Helper: timer periods since the last step, for the spacing check
    logic [WAIT_W:0]   since_q;
    logic [WAIT_W-1:0] lastLoad_q;
    logic              fired_q;
    always_ff @(posedge clock) begin
        if (!reset_n || !enable_q) begin
            since_q    <= '0;
            lastLoad_q <= 8'h00;
            fired_q    <= 1'b0;
        end else if (stepFire) begin
            since_q    <= '0;
            lastLoad_q <= waitLoad;
            fired_q    <= 1'b1;
        end else if (timerPeriodEnd && !since_q[WAIT_W]) begin
            since_q    <= since_q + 9'h001;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_ovRaise;
        stepFire && comp.ov && !dir_q && (step_q[7:4] != 4'h0)
        && (min_q <= staging_q) && (staging_q < max_q);
    endsequence

    a_src_held_off: assert property (!enable_q |-> !bufferSourceSelect)
        else $error("source select high while adjustment disabled");
    a_src_set_level: assert property (
        enable_q && lvlAny && !ctrlWr |=> bufferSourceSelect)
        else $error("voltage level did not set source select");
    a_src_clear_block: assert property (
        bufferSourceSelect && lvlAny && ctrlWr && pwdata[BIT_EN] && !pwdata[BIT_SRC]
        |=> bufferSourceSelect)
        else $error("source select cleared while a voltage level stood");
    a_stage_zero_off: assert property (!enable_q |-> staging_q == RST_DUTY)
        else $error("staging duty nonzero while disabled");
    a_cmp_wait_zero: assert property (
        timerRunning && !timerZero |=> $stable(timerCompareValue))
        else $error("compare value changed away from counter zero");
    a_step_in_limits: assert property (
        stepFire && (min_q <= max_q)
        |=> (staging_q >= $past(min_q)) && (staging_q <= $past(max_q)))
        else $error("stepped duty outside limits");
    a_step_spacing: assert property (
        stepFire && fired_q |-> since_q >= {1'b0, lastLoad_q})
        else $error("steps closer than the programmed delay");
    a_ov_raise: assert property (s_ovRaise |=> staging_q > $past(staging_q))
        else $error("over-voltage with direction 0 did not raise duty");
    a_no_step_off: assert property (!enable_q |-> !stepFire)
        else $error("step taken while adjustment disabled");
    a_fw_load: assert property (
        fwCompareWrite && enable_q && enable_d && !bufferSourceSelect && !lvlAny
        |=> staging_q == $past(fwCompareData))
        else $error("firmware compare not loaded into staging");
    a_status_read: assert property (
        setupPh && !pwrite && hitCtrl
        |=> prdata[3:0] == {$past(comp.ov), $past(comp.uv), $past(comp.ocB), $past(comp.ocA)})
        else $error("status bits not shown on control read");

    // Limit writes land whole at the access edge
    a_max_low_write: assert property (
        accessW && hitMaxL |=> max_q[7:0] == $past(pwdata[7:0]))
        else $error("max low byte not written");
    a_max_high_write: assert property (
        accessW && hitMaxH |=> max_q[9:8] == $past(pwdata[1:0]))
        else $error("max high bits not written");
    a_min_low_write: assert property (
        accessW && hitMinL |=> min_q[7:0] == $past(pwdata[7:0]))
        else $error("min low byte not written");
    a_min_high_write: assert property (
        accessW && hitMinH |=> min_q[9:8] == $past(pwdata[1:0]))
        else $error("min high bits not written");

    // Stray ones in unused bits would break software read-modify-write
    a_high_read_zero: assert property (
        setupPh && !pwrite && (hitMaxH || hitMinH || hitStgH) |=> prdata[7:2] == 6'h00)
        else $error("unused high bits read nonzero");
    a_ctrl_gap_zero: assert property (
        setupPh && !pwrite && hitCtrl |=> !prdata[4])
        else $error("unused control bit read nonzero");
    a_stage_write_refused: assert property (
        psel && penable && pready && pwrite && (hitStgH || hitStgL) |-> pslverr)
        else $error("staging write not refused");

    // Direction checked where a limit cannot block the move, step size only where no limit can clip
    sequence s_uvLower;
        stepFire && comp.uv && !comp.ov && !dir_q && (step_q[3:0] != 4'h0)
        && (min_q < staging_q) && (staging_q <= max_q);
    endsequence
    sequence s_ovLower;
        stepFire && comp.ov && dir_q && (step_q[7:4] != 4'h0)
        && (min_q < staging_q) && (staging_q <= max_q);
    endsequence
    sequence s_ovFullStep;
        stepFire && comp.ov && !dir_q && (staging_q >= min_q)
        && ({1'b0, staging_q} + {7'h00, step_q[7:4]} <= {1'b0, max_q});
    endsequence
    sequence s_uvFullStep;
        stepFire && comp.uv && !comp.ov && !dir_q && (staging_q <= max_q)
        && ({1'b0, staging_q} >= {1'b0, min_q} + {7'h00, step_q[3:0]});
    endsequence
    a_uv_lower: assert property (s_uvLower |=> staging_q < $past(staging_q))
        else $error("under-voltage did not lower duty");
    a_ov_reversed: assert property (s_ovLower |=> staging_q < $past(staging_q))
        else $error("reversed over-voltage did not lower duty");
    a_ov_step_size: assert property (
        s_ovFullStep |=> staging_q == $past(staging_q) + {6'h00, $past(step_q[7:4])})
        else $error("over-voltage step size wrong");
    a_uv_step_size: assert property (
        s_uvFullStep |=> staging_q == $past(staging_q) - {6'h00, $past(step_q[3:0])})
        else $error("under-voltage step size wrong");

    // Spacing load, compare transfer and source release
    a_hold_wait_load: assert property (
        stepFire |=> (state_q == ST_HOLD) && (wait_q == $past(waitLoad)))
        else $error("spacing count not loaded");
    a_src_clear_free: assert property (
        enable_q && ctrlWr && pwdata[BIT_EN] && !pwdata[BIT_SRC] && !lvlAny
        |=> !bufferSourceSelect)
        else $error("source clear refused while levels quiet");
    a_cmp_at_zero: assert property (
        timerRunning && timerZero && enable_q |=> timerCompareValue == $past(staging_q))
        else $error("compare missed staging at counter zero");

    // Reset itself is checked, so the default disable is overridden here
    a_reset_clear: assert property (disable iff (1'b0)
        !reset_n |=> !enable_q && !dir_q && !bufferSourceSelect)
        else $error("control bits not cleared by reset");
endmodule

// file: pdadj_timer_model.sv
`timescale 1ns/1ps
// PWM timer stand-in: counts while run is high, clears to zero when stopped
module pdadj_timer_model #(
    parameter int PERIOD = 6
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // Control from the bench
    input  wire logic run,
    // Timer events
    output logic      timerRunning,
    output logic      timerZero,
    output logic      timerPeriodEnd
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // Counter wraps at the period end, as a compare-match clear would
    assign cnt_d = (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
    always_ff @(posedge clock) begin
        if (!reset_n || !run) cnt_q <= 8'h00;
        else cnt_q <= cnt_d;
    end

    // A stopped timer gives no events at all
    assign timerRunning   = run;
    assign timerZero      = run && cnt_q == 8'h00;
    assign timerPeriodEnd = run && cnt_q == 8'(PERIOD - 1);
endmodule

// file: pdadj_ctrl_test.sv
`timescale 1ns/1ps
module pdadj_ctrl_test;
    import pdadj_pkg::*;
    localparam int P = 6;
    logic              clock, reset_n, psel, penable, pwrite, run, err;
    logic              pready, pslverr, fwCompareWrite, bufferSourceSelect;
    logic              timerRunning, timerZero, timerPeriodEnd, dir, useOv, up;
    logic [7:0]        paddr, d;
    logic [7:0]        ofs [9];
    logic [31:0]       pwdata, prdata, rd;
    logic [3:0]        st;
    logic [DUTY_W-1:0] fwCompareData, timerCompareValue, cv, v;
    pdadj_comp_t       comp;
    int                n_fail, cmp_count, seed, cyc, t, t2, t3, k, j, n;

    pdadj_ctrl dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .compIn(comp), .timerRunning(timerRunning),
        .timerZero(timerZero), .timerPeriodEnd(timerPeriodEnd),
        .fwCompareWrite(fwCompareWrite), .fwCompareData(fwCompareData),
        .timerCompareValue(timerCompareValue), .bufferSourceSelect(bufferSourceSelect));
    pdadj_timer_model #(.PERIOD(P)) tmr (.clock(clock), .reset_n(reset_n), .run(run),
        .timerRunning(timerRunning), .timerZero(timerZero), .timerPeriodEnd(timerPeriodEnd));

    // 10 MHz clock and a cycle count for step spacing
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) cyc <= cyc + 1;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One APB transfer; waits on pready instead of assuming a latency
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] dat);
        int m;
        m = 0;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, dat};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            m++;
        end while (pready !== 1'b1 && m < 20);
        rd  = prdata;
        err = pslverr;
        if (m >= 20) n_fail++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(nm, {24'h000000, exp}, rd);
    endtask

    task automatic fw(input logic [DUTY_W-1:0] val);
        @(posedge clock);
        fwCompareWrite <= 1'b1;
        fwCompareData  <= val;
        @(posedge clock);
        fwCompareWrite <= 1'b0;
    endtask

    // Bounded waits on the compare value fed to the timer
    task automatic waitVal(input logic [DUTY_W-1:0] val);
        int m;
        m = 0;
        while (timerCompareValue !== val && m < 100) begin
            @(posedge clock);
            m++;
        end
        chk("compare", val, timerCompareValue);
    endtask

    task automatic waitMove(output int tm);
        int m;
        m = 0;
        cv = timerCompareValue;
        while (timerCompareValue === cv && m < 400) begin
            @(posedge clock);
            m++;
        end
        tm = cyc;
        if (m >= 400) n_fail++;
    endtask

    // Saturating step worked out independently of the design
    function automatic logic [DUTY_W-1:0] nxt(input logic [DUTY_W-1:0] x,
            input logic [3:0] s, input logic u);
        logic [DUTY_W:0] r;
        r = u ? {1'b0, x} + s : {1'b0, x} - s;
        if (r > 11'h12a) r = 11'h12a;
        if (r < 11'h116) r = 11'h116;
        return r[DUTY_W-1:0];
    endfunction

    // Hang guard
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        summarize();
    end

    // Main sequence
    initial begin
        seed = 97970;
        n_fail = 0;
        cmp_count = 0;
        cyc = 0;
        {reset_n, psel, penable, pwrite, run, fwCompareWrite} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        fwCompareData = 10'h000;
        comp = pdadj_comp_t'(4'h0);
        ofs = '{OFS_CTRL, OFS_DELAY, OFS_STEP, OFS_MAXH, OFS_MAXL, OFS_MINH, OFS_MINL,
                OFS_STAGEH, OFS_STAGEL};
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        for (k = 0; k < 9; k++) rdchk("reset value", ofs[k], 8'h00);
        apb(1'b0, 8'h24, 8'h00);
        chk("unmapped error", 1'b1, err);
        apb(1'b1, OFS_STAGEL, 8'h5a);
        chk("staging write error", 1'b1, err);
        rdchk("staging low", OFS_STAGEL, 8'h00);
        $display("test reset and map done");
        for (k = 0; k < 8; k++) begin
            d = 8'($random(seed));
            apb(1'b1, ofs[3 + k % 4], d);
            rdchk("limit", ofs[3 + k % 4], (k % 2 == 0) ? (d & 8'h03) : d);
        end
        $display("test limits done");
        apb(1'b1, OFS_CTRL, 8'h60);
        for (k = 0; k < 6; k++) begin
            @(posedge clock);
            comp <= pdadj_comp_t'(4'($random(seed)));
            repeat (4) @(posedge clock);
            rdchk("status", OFS_CTRL, {4'h4, 4'(comp)});
            chk("source held", 1'b0, bufferSourceSelect);
        end
        @(posedge clock);
        comp <= pdadj_comp_t'(4'h0);
        $display("test status done");
        // Limits 0x116..0x12a, over step 4, under step 3, delay field 1
        apb(1'b1, OFS_MAXH, 8'h01);
        apb(1'b1, OFS_MAXL, 8'h2a);
        apb(1'b1, OFS_MINH, 8'h01);
        apb(1'b1, OFS_MINL, 8'h16);
        apb(1'b1, OFS_STEP, 8'h43);
        apb(1'b1, OFS_DELAY, 8'h01);
        run <= 1'b1;
        for (k = 0; k < 4; k++) begin
            dir = k[1];
            useOv = !k[0];
            up = useOv ? !dir : dir;
            st = useOv ? 4'h4 : 4'h3;
            apb(1'b1, OFS_CTRL, {1'b1, dir, 6'h00});
            fw(10'h120);
            waitVal(10'h120);
            @(posedge clock);
            comp <= pdadj_comp_t'(useOv ? 4'h8 : 4'h4);
            v = 10'h120;
            for (j = 0; j < 3; j++) begin
                waitMove(t);
                if (j == 1) t2 = t;
                t3 = t;
                v = nxt(v, st, up);
                chk("step", v, timerCompareValue);
                if (j == 0) begin
                    fw(10'h3ff);
                    apb(1'b1, OFS_CTRL, {1'b1, dir, 6'h00});
                    rdchk("source set", OFS_CTRL, {1'b1, dir, 2'b10, useOv, !useOv, 2'b00});
                    chk("source port", 1'b1, bufferSourceSelect);
                end
            end
            chk("step spacing", 4 * P, t3 - t2);
            @(posedge clock);
            comp <= pdadj_comp_t'(4'h0);
            repeat (4) @(posedge clock);
            apb(1'b1, OFS_CTRL, {1'b1, dir, 6'h00});
            rdchk("source cleared", OFS_CTRL, {1'b1, dir, 6'h00});
            $display("test adjust case %0d done", k);
        end
        apb(1'b1, OFS_CTRL, 8'h00);
        rdchk("staging high off", OFS_STAGEH, 8'h00);
        rdchk("staging low off", OFS_STAGEL, 8'h00);
        @(posedge clock);
        comp <= pdadj_comp_t'(4'h8);
        fw(10'h2a5);
        waitVal(10'h2a5);
        repeat (60) @(posedge clock);
        chk("no step when off", 10'h2a5, timerCompareValue);
        rdchk("status off", OFS_CTRL, 8'h08);
        n = 0;
        while (timerZero !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        fw(10'h15a);
        repeat (2) @(posedge clock);
        chk("held until zero", 10'h2a5, timerCompareValue);
        waitVal(10'h15a);
        run <= 1'b0;
        fw(10'h0f0);
        repeat (3) @(posedge clock);
        chk("stopped timer", 10'h0f0, timerCompareValue);
        $display("test disable and timer done");
        summarize();
    end
endmodule
